// file: ppx_consts.vh
`ifndef PPX_CONSTS_VH
`define PPX_CONSTS_VH

// Register byte offsets on the AXI4-Lite slave.
`define PPX_OFS_ROUTE_LO 8'h00
`define PPX_OFS_ROUTE_HI 8'h04
`define PPX_OFS_SKIP 8'h08
`define PPX_OFS_IN_MODE 8'h0C
`define PPX_OFS_OUT_MODE 8'h10
`define PPX_OFS_LATCH 8'h14
`define PPX_OFS_PIN_READ 8'h18
`define PPX_OFS_SS_MODE 8'h1C
`define PPX_OFS_ROUTED 8'h20

// Reset values.
`define PPX_RST_ROUTE 8'h00
`define PPX_RST_SKIP 16'h0000
`define PPX_RST_IN_MODE 17'h1_FFFF
`define PPX_RST_OUT_MODE 17'h0_0000
`define PPX_RST_LATCH 17'h1_FFFF
`define PPX_RST_SS_MODE 2'b00

// Field positions in routing_select_low.
`define PPX_LO_UART 0
`define PPX_LO_SPI 1
`define PPX_LO_SMB 2
`define PPX_LO_SYSCK 3
`define PPX_LO_CMP 4
`define PPX_LO_CMPA 5
// Field positions in routing_select_high.
`define PPX_HI_CC_LSB 0
`define PPX_HI_CNT 3
`define PPX_HI_TMR0 4
`define PPX_HI_TMR1 5
`define PPX_HI_ENABLE 6
`define PPX_HI_PUDIS 7

// Slave select mode code that means three-wire operation.
`define PPX_SS_THREE_WIRE 2'b00

// Resource indices, in priority order.
`define PPX_R_TX 0
`define PPX_R_RX 1
`define PPX_R_SCK 2
`define PPX_R_MISO 3
`define PPX_R_MOSI 4
`define PPX_R_NSS 5
`define PPX_R_SDA 6
`define PPX_R_SCL 7
`define PPX_R_CMP 8
`define PPX_R_CMPA 9
`define PPX_R_SYSCK 10
`define PPX_R_CC0 11
`define PPX_R_CC1 12
`define PPX_R_CC2 13
`define PPX_R_CNT 14
`define PPX_R_TMR0 15
`define PPX_R_TMR1 16

// Fixed UART pins.
`define PPX_PIN_TX 4
`define PPX_PIN_RX 5

// AXI responses.
`define PPX_RESP_OKAY 2'b00
`define PPX_RESP_SLVERR 2'b10

`endif

// file: ppx_crossbar.v
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "ppx_consts.vh"
// Functional notes
// - Selected resources take lowest free pin, UART first.
// - UART transmit fixed P0.4, receive fixed P0.5.
// - An assigned pin is passed over afterwards.
// - Skip-masked pins count as already taken.
// - SMBus takes two pins; UART takes two.
// - Leftover pins stay ordinary port pins.
// - Slave select routed only in four-wire mode.
// - Only P0.0 to P1.7 are routable, unskipped ones except for UART.
// - Input mode 1 digital, 0 analog; reset digital.
// - Analog pin: no pull-up, driver or receiver.
// - Output mode bit picks open-drain/push-pull, except on SMBus pins.
// - SMBus pins always open-drain.
// - Pull-up disable 0 pulls open-drain pins only.
// - Pull-up off while pin drives low.
// - Until enabled, all pins are plain inputs.
// - Output drivers off while crossbar disabled.
// - Event functions see digital pins, never analog.
// - Digital pin transition can raise an event.
// - Analog pin reads 0; digital reads pad level.
// - Capture field: 00 none, 11 all three lines.
module ppx_crossbar #(
  parameter NPIN = 17,
  parameter NXB = 16,
  parameter NRES = 17
) (
  // Clock and synchronous active-low reset.
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address channel.
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data channel.
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response channel.
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address channel.
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data channel.
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Peripheral side, one bit per resource in priority order.
  input wire [NRES-1:0] periph_out,
  input wire [NRES-1:0] periph_drive,
  output reg [NRES-1:0] periph_in,
  // Pad side, one bit per pin, P2.0 at the top.
  input wire [NPIN-1:0] pad_in,
  output reg [NPIN-1:0] pad_out,
  output reg [NPIN-1:0] pad_oe,
  output reg [NPIN-1:0] pad_pullup,
  // Event side.
  output reg [NPIN-1:0] event_level,
  output reg [NPIN-1:0] event_change
);

  // Software-visible registers.
  reg [7:0] routing_select_low_ff; // Resource enables, low group.
  reg [7:0] routing_select_high_ff; // Resource enables, enable and pull-up control.
  reg [NXB-1:0] pin_skip_mask_ff; // Skip bit n belongs to pin n.
  reg [NPIN-1:0] input_mode_select_ff; // 1 selects a digital input.
  reg [NPIN-1:0] output_mode_select_ff; // 1 selects push-pull.
  reg [NPIN-1:0] port_latch_ff; // Port output values.
  reg [1:0] slave_select_mode_ff; // SPI slave select mode.
  // Routing state.
  reg [NXB*5-1:0] map_ff; // Resource index per routed pin.
  reg [NXB-1:0] routed_ff; // Pin carries a resource.
  reg [NXB*5-1:0] nxt_map;
  reg [NXB-1:0] nxt_routed;
  // Pad synchronisers and readback.
  reg [NPIN-1:0] pad_meta_ff; // First stage, read only by the second.
  reg [NPIN-1:0] pad_sync_ff; // Second stage.
  reg [NPIN-1:0] nxt_pad_out;
  reg [NPIN-1:0] nxt_pad_oe;
  reg [NPIN-1:0] nxt_pad_pullup;
  reg [NRES-1:0] nxt_periph_in;
  reg [NRES-1:0] res_en;
  reg [NXB-1:0] taken;
  reg found;
  // Bus holding registers.
  reg [7:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  reg [31:0] nxt_rdata;
  reg nxt_rerr;
  integer r;
  integer p;
  integer q;

  // Readback is the pad level for digital pins and zero for analog pins.
  wire [NPIN-1:0] pin_read = pad_sync_ff & input_mode_select_ff;
  wire xb_on = routing_select_high_ff[`PPX_HI_ENABLE];
  wire pu_dis = routing_select_high_ff[`PPX_HI_PUDIS];
  wire [1:0] cc_field = routing_select_high_ff[`PPX_HI_CC_LSB +: 2];

  // Merges write data into an old value under the byte strobes.
  function [31:0] strb_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    integer b;
    begin
      strb_merge = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          strb_merge[b*8 +: 8] = new_v[b*8 +: 8];
        end
      end
    end
  endfunction

  // True when the resource drives its pin open-drain whatever the mode bit.
  function is_smbus;
    input [4:0] res;
    begin
      is_smbus = (res == `PPX_R_SDA) || (res == `PPX_R_SCL);
    end
  endfunction

  // Works out which resources are selected.
  always @* begin
    res_en = {NRES{1'b0}};
    res_en[`PPX_R_TX] = routing_select_low_ff[`PPX_LO_UART];
    res_en[`PPX_R_RX] = routing_select_low_ff[`PPX_LO_UART];
    res_en[`PPX_R_SCK] = routing_select_low_ff[`PPX_LO_SPI];
    res_en[`PPX_R_MISO] = routing_select_low_ff[`PPX_LO_SPI];
    res_en[`PPX_R_MOSI] = routing_select_low_ff[`PPX_LO_SPI];
    // Three-wire SPI leaves slave select off the pins.
    res_en[`PPX_R_NSS] = routing_select_low_ff[`PPX_LO_SPI] &&
      (slave_select_mode_ff != `PPX_SS_THREE_WIRE);
    res_en[`PPX_R_SDA] = routing_select_low_ff[`PPX_LO_SMB];
    res_en[`PPX_R_SCL] = routing_select_low_ff[`PPX_LO_SMB];
    res_en[`PPX_R_CMP] = routing_select_low_ff[`PPX_LO_CMP];
    res_en[`PPX_R_CMPA] = routing_select_low_ff[`PPX_LO_CMPA];
    res_en[`PPX_R_SYSCK] = routing_select_low_ff[`PPX_LO_SYSCK];
    // Each capture field code adds one line.
    res_en[`PPX_R_CC0] = (cc_field != 2'b00);
    res_en[`PPX_R_CC1] = cc_field[1];
    res_en[`PPX_R_CC2] = (cc_field == 2'b11);
    res_en[`PPX_R_CNT] = routing_select_high_ff[`PPX_HI_CNT];
    res_en[`PPX_R_TMR0] = routing_select_high_ff[`PPX_HI_TMR0];
    res_en[`PPX_R_TMR1] = routing_select_high_ff[`PPX_HI_TMR1];
  end

  // Priority search: each selected resource after the UART pair gets the lowest free pin, if one is left.
  always @* begin
    nxt_map = {NXB*5{1'b0}};
    nxt_routed = {NXB{1'b0}};
    taken = pin_skip_mask_ff;
    found = 1'b0;
    // The UART pair ignores skips and always lands on fixed pins.
    if (res_en[`PPX_R_TX]) begin
      // Resource codes are cut to the five-bit map field on purpose.
      r = `PPX_R_TX;
      nxt_map[`PPX_PIN_TX*5 +: 5] = r[4:0];
      r = `PPX_R_RX;
      nxt_map[`PPX_PIN_RX*5 +: 5] = r[4:0];
      nxt_routed[`PPX_PIN_TX] = 1'b1;
      nxt_routed[`PPX_PIN_RX] = 1'b1;
      taken[`PPX_PIN_TX] = 1'b1;
      taken[`PPX_PIN_RX] = 1'b1;
    end
    // Remaining resources in fixed priority order.
    for (r = `PPX_R_SCK; r < NRES; r = r + 1) begin
      found = 1'b0;
      if (res_en[r]) begin
        // Lowest pin index first, P0 then P1.
        for (p = 0; p < NXB; p = p + 1) begin
          if (!found && !taken[p]) begin
            found = 1'b1;
            taken[p] = 1'b1;
            nxt_map[p*5 +: 5] = r[4:0];
            nxt_routed[p] = 1'b1;
          end
        end
      end
    end
  end

  // Routing state only holds while the crossbar is enabled.
  always @(posedge aclk) begin
    if (!aresetn) begin
      map_ff <= {NXB*5{1'b0}};
      routed_ff <= {NXB{1'b0}};
    end else if (xb_on) begin
      map_ff <= nxt_map;
      routed_ff <= nxt_routed;
    end else begin
      map_ff <= {NXB*5{1'b0}};
      routed_ff <= {NXB{1'b0}};
    end
  end

  // Pad drive, pull-up and peripheral input per pin.
  always @* begin : pad_drive
    reg val;
    reg want;
    reg od;
    reg [4:0] res;
    val = 1'b1;
    want = 1'b0;
    od = 1'b0;
    res = 5'd0;
    nxt_pad_out = {NPIN{1'b0}};
    nxt_pad_oe = {NPIN{1'b0}};
    nxt_pad_pullup = {NPIN{1'b0}};
    nxt_periph_in = {NRES{1'b0}};
    for (q = 0; q < NPIN; q = q + 1) begin
      res = 5'd0;
      od = !output_mode_select_ff[q];
      if (q < NXB && routed_ff[q]) begin
        // Pin carries a resource.
        res = map_ff[q*5 +: 5];
        val = periph_out[res];
        want = periph_drive[res];
        if (is_smbus(res)) begin
          od = 1'b1;
        end
        nxt_periph_in[res] = pin_read[q];
      end else begin
        // Leftover pins and P2.0 behave as general port pins.
        val = port_latch_ff[q];
        want = 1'b1;
      end
      if (!xb_on || !input_mode_select_ff[q]) begin
        // Disabled crossbar or analog pin: driver off.
        nxt_pad_oe[q] = 1'b0;
        nxt_pad_out[q] = 1'b0;
      end else if (od) begin
        // Open-drain pulls low only.
        nxt_pad_oe[q] = want && !val;
        nxt_pad_out[q] = 1'b0;
      end else begin
        nxt_pad_oe[q] = want;
        nxt_pad_out[q] = val;
      end
      // Pull-up on digital open-drain pins that are not pulling low.
      // Push-pull pins never get the pull-up, so the disable bit cannot touch them.
      nxt_pad_pullup[q] = input_mode_select_ff[q] && od && !pu_dis
        && !nxt_pad_oe[q];
    end
  end

  // Pad synchroniser, registered pad outputs and event detection.
  always @(posedge aclk) begin
    if (!aresetn) begin
      pad_meta_ff <= {NPIN{1'b0}};
      pad_sync_ff <= {NPIN{1'b0}};
      pad_out <= {NPIN{1'b0}};
      pad_oe <= {NPIN{1'b0}};
      pad_pullup <= {NPIN{1'b0}};
      periph_in <= {NRES{1'b0}};
      event_level <= {NPIN{1'b0}};
      event_change <= {NPIN{1'b0}};
    end else begin
      pad_meta_ff <= pad_in;
      pad_sync_ff <= pad_meta_ff;
      pad_out <= nxt_pad_out;
      pad_oe <= nxt_pad_oe;
      pad_pullup <= nxt_pad_pullup;
      periph_in <= nxt_periph_in;
      // Analog pins read zero so they never raise an event.
      event_level <= pin_read;
      event_change <= (pin_read ^ event_level) & input_mode_select_ff;
    end
  end

  // Read data mux.
  always @* begin
    nxt_rdata = 32'h0000_0000;
    nxt_rerr = 1'b0;
    case (s_axi_araddr)
      `PPX_OFS_ROUTE_LO: nxt_rdata[7:0] = routing_select_low_ff;
      `PPX_OFS_ROUTE_HI: nxt_rdata[7:0] = routing_select_high_ff;
      `PPX_OFS_SKIP: nxt_rdata[NXB-1:0] = pin_skip_mask_ff;
      `PPX_OFS_IN_MODE: nxt_rdata[NPIN-1:0] = input_mode_select_ff;
      `PPX_OFS_OUT_MODE: nxt_rdata[NPIN-1:0] = output_mode_select_ff;
      `PPX_OFS_LATCH: nxt_rdata[NPIN-1:0] = port_latch_ff;
      `PPX_OFS_PIN_READ: nxt_rdata[NPIN-1:0] = pin_read;
      `PPX_OFS_SS_MODE: nxt_rdata[1:0] = slave_select_mode_ff;
      `PPX_OFS_ROUTED: nxt_rdata[NXB-1:0] = routed_ff;
      default: nxt_rerr = 1'b1;
    endcase
  end

  // AXI4-Lite slave: one write and one read in flight.
  always @(posedge aclk) begin : axi_slave
    reg [31:0] m;
    m = strb_merge(32'h0000_0000, 32'h0000_0000, 4'h0);
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PPX_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PPX_RESP_OKAY;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      routing_select_low_ff <= `PPX_RST_ROUTE;
      routing_select_high_ff <= `PPX_RST_ROUTE;
      pin_skip_mask_ff <= `PPX_RST_SKIP;
      input_mode_select_ff <= `PPX_RST_IN_MODE;
      output_mode_select_ff <= `PPX_RST_OUT_MODE;
      port_latch_ff <= `PPX_RST_LATCH;
      slave_select_mode_ff <= `PPX_RST_SS_MODE;
    end else begin
      // Capture write address and data in either order.
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_ff <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      // Both halves held: perform the write and answer.
      if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `PPX_RESP_OKAY;
        case (awaddr_ff)
          `PPX_OFS_ROUTE_LO: begin
            m = strb_merge({24'h00_0000, routing_select_low_ff}, wdata_ff, wstrb_ff);
            routing_select_low_ff <= {2'b00, m[5:0]};
          end
          `PPX_OFS_ROUTE_HI: begin
            m = strb_merge({24'h00_0000, routing_select_high_ff}, wdata_ff, wstrb_ff);
            routing_select_high_ff <= {m[7:3], 1'b0, m[1:0]};
          end
          `PPX_OFS_SKIP: begin
            m = strb_merge({16'h0000, pin_skip_mask_ff}, wdata_ff, wstrb_ff);
            pin_skip_mask_ff <= m[NXB-1:0];
          end
          `PPX_OFS_IN_MODE: begin
            m = strb_merge({15'h0000, input_mode_select_ff}, wdata_ff, wstrb_ff);
            input_mode_select_ff <= m[NPIN-1:0];
          end
          `PPX_OFS_OUT_MODE: begin
            m = strb_merge({15'h0000, output_mode_select_ff}, wdata_ff, wstrb_ff);
            output_mode_select_ff <= m[NPIN-1:0];
          end
          `PPX_OFS_LATCH: begin
            m = strb_merge({15'h0000, port_latch_ff}, wdata_ff, wstrb_ff);
            port_latch_ff <= m[NPIN-1:0];
          end
          `PPX_OFS_SS_MODE: begin
            m = strb_merge({30'h0000_0000, slave_select_mode_ff}, wdata_ff, wstrb_ff);
            slave_select_mode_ff <= m[1:0];
          end
          // Read-only status registers accept and drop writes.
          `PPX_OFS_PIN_READ: s_axi_bresp <= `PPX_RESP_OKAY;
          `PPX_OFS_ROUTED: s_axi_bresp <= `PPX_RESP_OKAY;
          default: s_axi_bresp <= `PPX_RESP_SLVERR;
        endcase
      end
      // Response taken: reopen the write channels.
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      // Read address taken: answer on the next edge.
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= nxt_rdata;
        s_axi_rresp <= nxt_rerr ? `PPX_RESP_SLVERR : `PPX_RESP_OKAY;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// file: ppx_monitor.sv
`timescale 1ns/1ps
// Bus handshake and pad drive checks, seen only from the crossbar ports.
module ppx_monitor #(
  parameter NPIN = 17
) (
  // Clock and synchronous active-low reset.
  input wire aclk,
  input wire aresetn,
  // Bus handshakes.
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Pad drivers.
  input wire [NPIN-1:0] pad_out,
  input wire [NPIN-1:0] pad_oe,
  input wire [NPIN-1:0] pad_pullup
);
  // All checks share the bus clock; all but a_reset_quiet rest while reset is low.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response changed before it was taken");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before it was taken");
  a_bresp_taken: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channels not reopened after response");
  a_rdata_taken: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not reopened after data");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data late");
  a_busy_no_ready: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write accepted during response");
  a_bresp_legal: assert property (s_axi_bvalid |-> !s_axi_bresp[0])
    else $error("illegal write response code");
  a_pullup_low_off: assert property ((pad_oe & ~pad_out & pad_pullup) == 0)
    else $error("pull-up on while pin drives low");
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> pad_oe == 0 && !s_axi_bvalid)
    else $error("outputs active after reset");
endmodule

bind ppx_crossbar ppx_monitor #(.NPIN(NPIN)) u_mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pad_out, .pad_oe, .pad_pullup);

// file: ppx_pad_model.sv
`timescale 1ns/1ps
// Pads and the outside world: settles each pin from all its drivers.
module ppx_pad_model #(
  parameter NPIN = 17
) (
  // Clock for the floating pattern.
  input wire aclk,
  // Device pad drivers.
  input wire [NPIN-1:0] pad_out,
  input wire [NPIN-1:0] pad_oe,
  input wire [NPIN-1:0] pad_pullup,
  // Outside drivers set by the bench.
  input wire [NPIN-1:0] ext_en,
  input wire [NPIN-1:0] ext_val,
  // Settled pad level.
  output wire [NPIN-1:0] pad_in
);
  // A pin nobody holds flips every cycle, so no stale value can pass.
  reg [NPIN-1:0] float_ff = {NPIN{1'b0}};
  always @(posedge aclk) begin
    float_ff <= ~float_ff;
  end
  // Device drive wins, then the outside driver, then the weak pull-up.
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) | (~pad_oe & ~ext_en & (pad_pullup | float_ff));
endmodule

// file: ppx_tb.sv
`timescale 1ns/1ps
`include "ppx_consts.vh"
// Self-checking bench: register map, routing, pad drive, readback and events.
module testbench;
  // Clock, reset and bus.
  reg aclk = 1'b0, aresetn = 1'b0;
  reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg [31:0] s_axi_wdata = 32'h0000_0000;
  reg [3:0] s_axi_wstrb = 4'hF;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  // Peripheral side and pads.
  reg [16:0] periph_out = 17'h0_0000, periph_drive = 17'h0_0000, ext_en = 17'h1_FFFF, ext_val = 17'h0_0000;
  wire [16:0] periph_in, pad_in, pad_out, pad_oe, pad_pullup, event_level, event_change;
  // Bench state and expectations.
  integer miscompares = 0, num_checks = 0, k, n;
  integer pr [0:15];
  reg [16:0] in_m, out_m, latch, e_oe, e_out, e_pu, e_rb, e_pi;
  reg [15:0] skip, e_rt;
  reg [7:0] lo, hi;
  reg [1:0] ss, rr;
  reg [31:0] rv;
  reg seen;

  always #10 aclk = ~aclk;

  ppx_crossbar dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .periph_out, .periph_drive,
    .periph_in, .pad_in, .pad_out, .pad_oe, .pad_pullup, .event_level, .event_change);
  ppx_pad_model pads (.aclk, .pad_out, .pad_oe, .pad_pullup, .ext_en, .ext_val, .pad_in);

  // Compares one value and counts it.
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    begin
      num_checks++;
      if (got !== exp) begin
        miscompares++;
        $display("ERROR %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask

  // One bus access; the answer is taken at the edge that shows it valid.
  task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q, output [1:0] r);
    integer t;
    begin
      t = 0;
      @(posedge aclk);
      if (w) begin
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
      end else begin
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
      end
      do begin
        @(posedge aclk);
        t++;
        if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
        if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while ((w ? s_axi_bvalid : s_axi_rvalid) !== 1'b1 && t < 50);
      q = s_axi_rdata;
      r = w ? s_axi_bresp : s_axi_rresp;
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      if (t >= 50) begin
        miscompares++;
        wrap_up;
      end
    end
  endtask

  // Works out pin assignment and every pad expectation from the settings.
  task plan;
    reg [16:0] en;
    reg [15:0] used;
    reg val, drv, od, lvl;
    integer r, p, q;
    begin
      en = {hi[5:3], &hi[1:0], hi[1], hi[1:0] != 2'b00, lo[3], lo[5], lo[4], {2{lo[2]}},
        lo[1] && ss != `PPX_SS_THREE_WIRE, {3{lo[1]}}, {2{lo[0]}}};
      used = skip;
      e_rt = 0;
      e_pi = 0;
      for (p = 0; p < 16; p++) pr[p] = -1;
      if (en[0]) begin
        pr[`PPX_PIN_TX] = 0;
        pr[`PPX_PIN_RX] = 1;
        used[5:4] = 2'b11;
      end
      for (r = 2; r < 17; r++) begin
        q = -1;
        for (p = 15; p >= 0; p--) if (!used[p]) q = p;
        if (en[r] && q >= 0) begin
          pr[q] = r;
          used[q] = 1'b1;
        end
      end
      for (p = 0; p < 17; p++) begin
        r = (p < 16 && hi[6]) ? pr[p] : -1;
        val = r >= 0 ? periph_out[r] : latch[p];
        drv = !hi[6] ? 1'b0 : r >= 0 ? periph_drive[r] : 1'b1;
        od = !out_m[p] || r == `PPX_R_SDA || r == `PPX_R_SCL;
        e_oe[p] = in_m[p] && drv && (!od || !val);
        e_out[p] = e_oe[p] && val;
        e_pu[p] = in_m[p] && od && !hi[7] && !(e_oe[p] && !val);
        lvl = e_oe[p] ? val : ext_val[p];
        e_rb[p] = in_m[p] && lvl;
        if (r >= 0) begin
          e_rt[p] = 1'b1;
          e_pi[r] = e_rb[p];
        end
      end
    end
  endtask

  // Main sequence.
  initial begin
    rv = $urandom(90);
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("oe_reset", pad_oe, 0);
    chk("pu_reset", pad_pullup, 17'h1_FFFF);
    for (k = 0; k < 8; k++) if (k != 6) begin
      xfer(0, {k[5:0], 2'b00}, 0, rv, rr);
      chk("reg_reset", rv, (k == 3 || k == 5) ? 32'h0001_FFFF : 0);
    end
    xfer(1, 8'h24, 32'h0000_FFFF, rv, rr);
    chk("bresp_unmapped", rr, `PPX_RESP_SLVERR);
    xfer(0, 8'h24, 0, rv, rr);
    chk("rresp_unmapped", {rr, rv[29:0]}, {`PPX_RESP_SLVERR, 30'h0});
    xfer(1, `PPX_OFS_PIN_READ, 32'h0000_0000, rv, rr);
    chk("bresp_readonly", rr, `PPX_RESP_OKAY);
    $display("test reset_and_map done");
    for (n = 0; n < 30; n++) begin
      skip = 16'($urandom & $urandom);
      lo = 8'($urandom);
      hi = 8'($urandom) | 8'h40;
      ss = 2'($urandom);
      case (n)
        0: begin skip = 16'h0030; lo = 8'h01; end
        1: begin skip = 16'h0000; lo = 8'h3F; hi = 8'h7B; ss = 2'b01; end
        2: begin skip = 16'h000C; lo = 8'h07; ss = 2'b00; end
        3: begin lo = 8'h3F; hi = 8'h00; end
        default: ;
      endcase
      in_m = 17'($urandom | $urandom);
      out_m = 17'($urandom);
      latch = 17'($urandom);
      periph_out <= 17'($urandom);
      periph_drive <= 17'($urandom);
      ext_val <= 17'($urandom);
      ext_en <= in_m;
      xfer(1, `PPX_OFS_IN_MODE, in_m, rv, rr);
      xfer(1, `PPX_OFS_OUT_MODE, out_m, rv, rr);
      xfer(1, `PPX_OFS_SKIP, skip, rv, rr);
      xfer(1, `PPX_OFS_SS_MODE, ss, rv, rr);
      xfer(1, `PPX_OFS_LATCH, latch, rv, rr);
      xfer(1, `PPX_OFS_ROUTE_LO, lo, rv, rr);
      xfer(1, `PPX_OFS_ROUTE_HI, hi, rv, rr);
      repeat (8) @(posedge aclk);
      plan;
      chk("pad_oe", pad_oe, e_oe);
      chk("pad_out", pad_out & pad_oe, e_out);
      chk("pad_pullup", pad_pullup, e_pu);
      chk("periph_in", periph_in, e_pi);
      chk("event_level", event_level, e_rb);
      xfer(0, `PPX_OFS_PIN_READ, 0, rv, rr);
      chk("pin_read", rv, e_rb);
      if (hi[6]) begin
        xfer(0, `PPX_OFS_ROUTED, 0, rv, rr);
        chk("routed", rv, e_rt);
      end
      k = -1;
      for (int p = 0; p < 17; p++) if (in_m[p] && !e_oe[p]) k = p;
      if (k >= 0) begin
        ext_val[k] <= !ext_val[k];
        seen = 1'b0;
        repeat (6) begin
          @(posedge aclk);
          seen = seen | (event_change[k] === 1'b1);
          chk("event_analog", event_change & ~in_m, 0);
        end
        chk("event_change", seen, 1);
      end
      $display("test routing %0d done", n);
    end
    wrap_up;
  end
endmodule
